// *** config_interlock_irq_status.sv ***
// Configuration hold interlock and sticky event status with interrupt output
//
// Function
// RULE1: While the hold bit is 1 the device stays in configuration and accepts register writes.
// RULE2: A serial write of 0 to the hold bit ends the configuration stage at once.
// RULE3: With the hold bit left low and unwritten, configuration ends when the timeout expires.
// RULE4: The configuration timeout is 95 ms.
// RULE5: The SoC writes the interlock register first, within the timeout, before other registers.
// RULE6: After its configuration writes the SoC clears the hold bit to resume operation.
// RULE7: Status bit 7 reads 1 while the interrupt output is held low by an unmasked event.
// RULE8: Writing 0 to bit 7 releases the interrupt output; writing 1 changes nothing.
// RULE9: Bit 4 is set on suspend entry and stays set until written 0; a 1 does nothing.
// RULE10: Bit 3 is set when the host configures the hub, holds until written 0, ignores 1.
// RULE11: Bit 2 is set on a port power update, holds until written 0, ignores 1.
// RULE12: A suspend entry drives the interrupt low only when the suspend mask bit is 1.
// RULE13: Status bits 6:5 and 1:0 read zero and each event flag is captured on its own.
// RULE14: Once low the interrupt output stays low until bit 7 is cleared.
`timescale 1ns/1ns
module config_interlock_irq_status
#(
  parameter int TIMEOUT_CYCLES = config_irq_pkg::CONFIG_TIMEOUT_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_suspend_evt,
  input wire logic i_host_cfg_evt,
  input wire logic i_port_power_evt,
  output logic [7:0] o_reg_rdata,
  output logic o_config_stage,
  output logic o_cfg_write_accept,
  output logic o_int_n
);
  import config_irq_pkg::*;

  logic hold;
  logic next_hold;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic int_n;
  logic next_int_n;
  logic wr_interlock;
  logic wr_status;
  logic wr_mask;
  logic zero_write;
  logic clr_summary;
  logic clr_suspend;
  logic clr_host_cfg;
  logic clr_port_power;
  logic [7:0] events;
  logic unmasked_event;

  // Sticky flag: hardware set wins over a software write of 0
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  assign wr_interlock = i_reg_wr && hit(i_reg_addr, INTERLOCK_OFFSET);
  assign wr_status = i_reg_wr && hit(i_reg_addr, STATUS_OFFSET);
  assign wr_mask = i_reg_wr && hit(i_reg_addr, MASK_OFFSET);
  assign zero_write = wr_interlock && !i_reg_wdata[HOLD_BIT]; // RULE2

  assign clr_summary = wr_status && !i_reg_wdata[SUMMARY_BIT]; // RULE8
  assign clr_suspend = wr_status && !i_reg_wdata[SUSPEND_BIT]; // RULE9
  assign clr_host_cfg = wr_status && !i_reg_wdata[HOST_CFG_BIT]; // RULE10
  assign clr_port_power = wr_status && !i_reg_wdata[PORT_POWER_BIT]; // RULE11

  always_comb
  begin
    events = 8'h00;
    events[SUSPEND_BIT] = i_suspend_evt;
    events[HOST_CFG_BIT] = i_host_cfg_evt;
    events[PORT_POWER_BIT] = i_port_power_evt;
  end

  // Mask gates each event onto the summary
  assign unmasked_event = |(events & mask & MASK_USED_MASK); // RULE12

  // Interlock hold bit and event mask
  always_comb
  begin
    next_hold = hold;
    next_mask = mask;
    if (wr_interlock)
    begin
      next_hold = i_reg_wdata[HOLD_BIT]; // RULE1
    end
    if (wr_mask)
    begin
      next_mask = i_reg_wdata & MASK_USED_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      hold <= HOLD_RESET;
      mask <= MASK_RESET;
    end
    else
    begin
      hold <= next_hold;
      mask <= next_mask;
    end
  end

  // Sticky event flags and summary
  always_comb
  begin
    next_status = 8'h00; // RULE13
    next_status[SUSPEND_BIT] = sticky(status[SUSPEND_BIT], events[SUSPEND_BIT],
                                      clr_suspend); // RULE9
    next_status[HOST_CFG_BIT] = sticky(status[HOST_CFG_BIT], events[HOST_CFG_BIT],
                                       clr_host_cfg); // RULE10
    next_status[PORT_POWER_BIT] = sticky(status[PORT_POWER_BIT], events[PORT_POWER_BIT],
                                         clr_port_power); // RULE11
    next_status[SUMMARY_BIT] = sticky(status[SUMMARY_BIT], unmasked_event,
                                      clr_summary); // RULE8
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  // Interrupt output follows the summary bit
  always_comb
  begin
    if (next_status[SUMMARY_BIT])
    begin
      next_int_n = 1'b0; // RULE14
    end
    else
    begin
      next_int_n = 1'b1; // RULE8
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      int_n <= 1'b1;
    end
    else
    begin
      int_n <= next_int_n;
    end
  end

  always_comb
  begin
    next_rdata = rdata;
    if (i_reg_rd)
    begin
      if (hit(i_reg_addr, INTERLOCK_OFFSET))
      begin
        next_rdata = {7'h00, hold} & INTERLOCK_USED_MASK;
      end
      else if (hit(i_reg_addr, STATUS_OFFSET))
      begin
        next_rdata = status & STATUS_USED_MASK; // RULE7
      end
      else if (hit(i_reg_addr, MASK_OFFSET))
      begin
        next_rdata = mask;
      end
      else
      begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  config_stage_ctrl
  #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  )
  u_stage
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_hold(hold),
    .i_zero_write(zero_write),
    .o_config_stage(o_config_stage)
  );

  assign o_cfg_write_accept = o_config_stage; // RULE1
  assign o_reg_rdata = rdata;
  assign o_int_n = int_n;
endmodule

// *** config_interlock_irq_status_tb_top.sv ***
// Testbench for the interlock and event status block
`timescale 1ns/1ns
module config_interlock_irq_status_tb_top;
  import config_irq_pkg::*;
  logic i_clk;
  logic i_rstn;
  logic wr;
  logic rd;
  logic stage;
  logic accept;
  logic int_n;
  logic [2:0] evt;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] v;
  int miscompares;
  int checks_done;
  config_interlock_irq_status #(.TIMEOUT_CYCLES(20)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_suspend_evt(evt[2]), .i_host_cfg_evt(evt[1]), .i_port_power_evt(evt[0]),
    .o_reg_rdata(rdata), .o_config_stage(stage), .o_cfg_write_accept(accept), .o_int_n(int_n));
  soc_model i_soc (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_soc.rd(a, v);
    chk("register", v, e);
  endtask
  task automatic pulse(input logic [2:0] e);
    @(negedge i_clk);
    evt = e;
    @(negedge i_clk);
    evt = 3'h0;
    @(negedge i_clk);
  endtask
  task automatic do_reset();
    i_rstn = 1'b0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rstn = 1'b1;
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #20000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    i_rstn = 1'b0;
    evt = 3'h0;
    miscompares = 0;
    checks_done = 0;
    do_reset();
    repeat (20) @(negedge i_clk);
    chk("stage", {7'h0, stage}, 8'h01);
    @(negedge i_clk);
    chk("stage", {7'h0, stage}, 8'h00);
    do_reset();
    i_soc.begin_cfg();
    repeat (30) @(negedge i_clk);
    chk("accept", {7'h0, accept}, 8'h01);
    chk("stage", {7'h0, stage}, 8'h01);
    rchk(INTERLOCK_OFFSET, 8'h01);
    i_soc.end_cfg(8'h10);
    @(negedge i_clk);
    chk("stage", {7'h0, stage}, 8'h00);
    rchk(MASK_OFFSET, 8'h10);
    rchk(INTERLOCK_OFFSET, 8'h00);
    pulse(3'b100);
    chk("int_n", {7'h0, int_n}, 8'h00);
    rchk(STATUS_OFFSET, 8'h90);
    pulse(3'b011);
    rchk(STATUS_OFFSET, 8'h9c);
    i_soc.wr(STATUS_OFFSET, 8'hff);
    rchk(STATUS_OFFSET, 8'h9c);
    i_soc.wr(STATUS_OFFSET, 8'h80);
    rchk(STATUS_OFFSET, 8'h80);
    pulse(3'b010);
    chk("int_n", {7'h0, int_n}, 8'h00);
    i_soc.wr(STATUS_OFFSET, 8'h7f);
    @(negedge i_clk);
    chk("int_n", {7'h0, int_n}, 8'h01);
    rchk(STATUS_OFFSET, 8'h08);
    i_soc.wr(STATUS_OFFSET, 8'h00);
    i_soc.wr(MASK_OFFSET, 8'h00);
    pulse(3'b100);
    chk("int_n", {7'h0, int_n}, 8'h01);
    rchk(STATUS_OFFSET, 8'h10);
    rchk(8'h55, 8'h00);
    fork
      i_soc.wr(STATUS_OFFSET, 8'h00);
      pulse(3'b100);
    join
    rchk(STATUS_OFFSET, 8'h10);
    i_soc.wr(MASK_OFFSET, 8'h08);
    pulse(3'b010);
    chk("int_n", {7'h0, int_n}, 8'h00);
    rchk(STATUS_OFFSET, 8'h98);
    fork
      i_soc.wr(STATUS_OFFSET, 8'h00);
      pulse(3'b010);
    join
    chk("int_n", {7'h0, int_n}, 8'h00);
    rchk(STATUS_OFFSET, 8'h88);
    print_verdict();
  end
endmodule

// *** config_irq_pkg.sv ***
// Constants shared by the configuration hold and event status logic
package config_irq_pkg;
  localparam logic [7:0] INTERLOCK_OFFSET = 8'he7;
  localparam logic [7:0] STATUS_OFFSET = 8'he8;
  localparam logic [7:0] MASK_OFFSET = 8'he9;
  localparam int HOLD_BIT = 0;
  localparam int SUMMARY_BIT = 7;
  localparam int SUSPEND_BIT = 4;
  localparam int HOST_CFG_BIT = 3;
  localparam int PORT_POWER_BIT = 2;
  localparam logic [7:0] STATUS_USED_MASK = 8'h9c;
  localparam logic [7:0] MASK_USED_MASK = 8'h1c;
  localparam logic [7:0] INTERLOCK_USED_MASK = 8'h01;
  localparam logic HOLD_RESET = 1'b0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CONFIG_TIMEOUT_MS = 95;
  localparam int CONFIG_TIMEOUT_CYCLES = CONFIG_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int TIMER_WIDTH = 24;
endpackage

// *** config_irq_props.sv ***
// Checker for the interlock and event status block
`timescale 1ns/1ns
module config_irq_props
  import config_irq_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 20
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_suspend_evt,
  input wire logic i_host_cfg_evt,
  input wire logic i_port_power_evt,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_config_stage,
  input wire logic o_cfg_write_accept,
  input wire logic o_int_n
);
  logic clr;
  logic evt;
  logic seen;
  int cnt;
  assign clr = i_reg_wr && i_reg_addr == STATUS_OFFSET && !i_reg_wdata[SUMMARY_BIT];
  assign evt = i_suspend_evt || i_host_cfg_evt || i_port_power_evt;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= 0;
      seen <= 1'b0;
    end
    else
    begin
      cnt <= (cnt < 1000) ? cnt + 1 : cnt;
      seen <= seen || (i_reg_wr && i_reg_addr == INTERLOCK_OFFSET);
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence zero_wr;
    i_reg_wr && i_reg_addr == INTERLOCK_OFFSET && !i_reg_wdata[HOLD_BIT];
  endsequence
  a_zero_exit: assert property (zero_wr |=> !o_config_stage)
    else $error("stage kept after zero write");
  a_stage_final: assert property (!o_config_stage |=> !o_config_stage)
    else $error("stage returned");
  a_accept_match: assert property (o_cfg_write_accept == o_config_stage)
    else $error("accept differs from stage");
  a_stage_early: assert property (!seen && cnt < TIMEOUT_CYCLES |-> o_config_stage)
    else $error("stage ended early");
  a_stage_late: assert property (!seen && cnt > TIMEOUT_CYCLES + 2 |-> !o_config_stage)
    else $error("stage outlived timeout");
  a_int_cause: assert property ($fell(o_int_n) |-> $past(evt))
    else $error("interrupt without event");
  a_int_hold: assert property (!o_int_n && !clr |=> !o_int_n)
    else $error("interrupt released early");
  a_int_release: assert property (clr && !evt |=> o_int_n)
    else $error("interrupt not released");
  a_resv_zero: assert property (i_reg_rd && i_reg_addr == STATUS_OFFSET |=>
    (o_reg_rdata & ~STATUS_USED_MASK) == 8'h00) else $error("reserved bits set");
endmodule
bind config_interlock_irq_status config_irq_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props
  (.i_clk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_suspend_evt,
  .i_host_cfg_evt, .i_port_power_evt, .o_reg_rdata, .o_config_stage, .o_cfg_write_accept,
  .o_int_n);

// *** config_stage_ctrl.sv ***
// Configuration stage state machine with its startup timeout counter
`timescale 1ns/1ns
module config_stage_ctrl
#(
  parameter int TIMEOUT_CYCLES = config_irq_pkg::CONFIG_TIMEOUT_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_hold,
  input wire logic i_zero_write,
  output logic o_config_stage
);
  import config_irq_pkg::*;

  typedef enum logic [1:0]
  {
    ST_CONFIG = 2'b01,
    ST_RUN = 2'b10
  } stage_e;

  localparam logic [TIMER_WIDTH-1:0] LAST_COUNT = TIMER_WIDTH'(TIMEOUT_CYCLES - 1);

  stage_e state;
  stage_e next_state;
  logic [TIMER_WIDTH-1:0] count;
  logic [TIMER_WIDTH-1:0] next_count;
  logic expired;
  logic next_expired;

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_expired = expired;
    case (state)
      ST_CONFIG:
      begin
        if (count == LAST_COUNT)
        begin
          next_expired = 1'b1; // RULE4
        end
        else
        begin
          next_count = count + TIMER_WIDTH'(1); // RULE4
        end
        if (i_zero_write)
        begin
          next_state = ST_RUN; // RULE2
        end
        else if (expired && !i_hold)
        begin
          next_state = ST_RUN; // RULE3
        end
        else
        begin
          next_state = ST_CONFIG; // RULE1
        end
      end
      ST_RUN:
      begin
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_CONFIG;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= ST_CONFIG;
      count <= '0;
      expired <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign o_config_stage = (state == ST_CONFIG);
endmodule

// *** soc_model.sv ***
// Serial master model issuing register reads and writes
`timescale 1ns/1ns
module soc_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  import config_irq_pkg::*;
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(negedge i_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rdata;
  endtask
  task automatic begin_cfg();
    wr(INTERLOCK_OFFSET, 8'h01);
  endtask
  task automatic end_cfg(input logic [7:0] m);
    wr(MASK_OFFSET, m);
    wr(INTERLOCK_OFFSET, 8'h00);
  endtask
endmodule
